// >>> src/pmas_pkg.sv
// pmas_pkg: constants and types for the power mode and auto-sleep block
// assumes a byte-wide register port driven by the device's serial slave
package pmas_pkg;
    localparam logic [7:0] PMAS_ADDR_MODE = 8'h88;
    localparam logic [7:0] PMAS_ADDR_GATE = 8'h8A;
    localparam logic [7:0] PMAS_ADDR_AUTO = 8'h8B;
    localparam logic [7:0] PMAS_ADDR_TLOW = 8'h8C;
    localparam logic [7:0] PMAS_ADDR_THIGH = 8'h8D;
    localparam logic [1:0] PMAS_MODE_SLEEP = 2'h0;
    localparam logic [1:0] PMAS_MODE_OPER = 2'h1;
    localparam int PMAS_BIT_PWM = 2;
    localparam int PMAS_BIT_KEY = 0;
    localparam int PMAS_BIT_AUTO = 0;
    localparam int PMAS_IVL_W = 11;
    localparam logic [10:0] PMAS_IVL_RESET = 11'h0FF;
    localparam logic [7:0] PMAS_GATE_RESET = 8'h00;
    localparam int PMAS_CLK_HZ = 10_000_000;
    localparam int PMAS_STEP_MS = 4;
    localparam int PMAS_STEP_CYC = PMAS_CLK_HZ / 1000 * PMAS_STEP_MS;
    // register write request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } pmas_req_type;
    // gate and power outputs
    typedef struct packed {
        logic pwm_clk_en;
        logic key_clk_en;
        logic pwm_kill;
        logic sleeping;
    } pmas_ctl_type;
    typedef enum logic [0:0] {PMAS_ST_OPER, PMAS_ST_SLEEP} pmas_state_type;
endpackage

// >>> src/pmas_step_timer.sv
// pmas_step_timer: restartable prescaler giving one pulse per 4 ms step
// assumes mclk at the package clock rate
`timescale 1ns/10ps
`default_nettype none
module pmas_step_timer
    import pmas_pkg::*;
#(
    parameter int STEP_CYC = PMAS_STEP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic restart,
    output logic step
);
    logic [31:0] cnt_reg; // cycles within the current step
    logic [31:0] cnt_next;
    logic step_reg;
    logic step_next;
    // restart aligns steps to the last event so a full step always elapses
    always_comb begin
        step_next = 1'b0;
        if (restart) begin
            cnt_next = '0;
        end else if (cnt_reg == 32'(STEP_CYC - 1)) begin
            cnt_next = '0;
            step_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 32'h1;
        end
    end
    // register stage
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= '0;
            step_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            step_reg <= step_next;
        end
    end
    assign step = step_reg;
endmodule
`default_nettype wire

// >>> src/pmas_top.sv
// pmas_top: operating mode, clock gates and automatic sleep entry
// assumes a byte register port from the serial slave on mclk, and a
// one-cycle activity pulse from the processing blocks on mclk
`timescale 1ns/10ps
`default_nettype none
module pmas_top
    import pmas_pkg::*;
#(
    parameter int STEP_CYC = PMAS_STEP_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire pmas_req_type req,
    input wire logic [7:0] rd_addr,
    input wire logic activity,
    output logic [7:0] rd_data,
    output pmas_ctl_type ctl
);
    pmas_state_type state_reg, state_next; // current operating mode
    logic [7:0] gate_reg, gate_next; // clock gate register
    logic auto_reg, auto_next; // auto-sleep enable
    logic [10:0] ivl_reg, ivl_next; // inactivity interval in steps
    logic [10:0] left_reg, left_next; // steps left before sleep
    logic [7:0] rd_reg, rd_next;
    pmas_ctl_type ctl_reg, ctl_next;
    logic step;
    logic armed; // counting is allowed
    logic expire;
    logic wr_sleep, wr_oper; // decoded mode writes

    // true for a write of the given code into the mode field
    // reserved codes 1x match neither decode, so they leave the mode alone
    function automatic logic mode_write_hit(input pmas_req_type r, input logic [1:0] code);
        return r.wr && r.addr == PMAS_ADDR_MODE && r.data[1:0] == code;
    endfunction

    // write decodes
    assign wr_sleep = mode_write_hit(req, PMAS_MODE_SLEEP);
    assign wr_oper = mode_write_hit(req, PMAS_MODE_OPER);
    assign armed = state_reg == PMAS_ST_OPER && auto_reg && ivl_reg != '0;
    // an event in the last step cycle wins and cancels the expiry
    assign expire = armed && step && left_reg == 11'h001 && !activity;

    // the prescaler sits in restart while idle, so the first step after
    // arming or after an event is always a whole step long
    pmas_step_timer #(.STEP_CYC(STEP_CYC)) u_step (
        .mclk(mclk),
        .rst(rst),
        .restart(activity || !armed),
        .step(step)
    );

    // register writes; reserved mode codes are ignored
    always_comb begin
        gate_next = gate_reg;
        auto_next = auto_reg;
        ivl_next = ivl_reg;
        if (req.wr) begin
            case (req.addr)
                PMAS_ADDR_GATE: begin
                    gate_next = 8'h00;
                    gate_next[PMAS_BIT_PWM] = req.data[PMAS_BIT_PWM];
                    gate_next[PMAS_BIT_KEY] = req.data[PMAS_BIT_KEY];
                end
                PMAS_ADDR_AUTO: auto_next = req.data[PMAS_BIT_AUTO];
                PMAS_ADDR_TLOW: ivl_next[7:0] = req.data;
                PMAS_ADDR_THIGH: ivl_next[10:8] = req.data[2:0];
                default: ivl_next = ivl_reg;
            endcase
        end
    end

    // mode machine and inactivity countdown
    always_comb begin
        state_next = state_reg;
        left_next = left_reg;
        case (state_reg)
            PMAS_ST_OPER: begin
                if (wr_sleep || expire) begin
                    state_next = PMAS_ST_SLEEP;
                end
            end
            PMAS_ST_SLEEP: begin
                if (wr_oper) begin
                    state_next = PMAS_ST_OPER;
                end
            end
            default: state_next = PMAS_ST_OPER;
        endcase
        // reload on any event or while idle, count down one per step
        if (activity || !armed) begin
            left_next = ivl_reg;
        end else if (step && left_reg != 11'h001) begin
            left_next = left_reg - 11'h001;
        end
    end

    // outputs and read data, all registered
    always_comb begin
        ctl_next.sleeping = state_next == PMAS_ST_SLEEP;
        ctl_next.pwm_kill = state_next == PMAS_ST_SLEEP;
        ctl_next.pwm_clk_en = gate_next[PMAS_BIT_PWM];
        ctl_next.key_clk_en = gate_next[PMAS_BIT_KEY];
        case (rd_addr)
            PMAS_ADDR_MODE: rd_next = (state_reg == PMAS_ST_OPER)
                ? {6'h00, PMAS_MODE_OPER} : {6'h00, PMAS_MODE_SLEEP};
            PMAS_ADDR_GATE: rd_next = gate_reg;
            PMAS_ADDR_AUTO: rd_next = {7'h00, auto_reg};
            PMAS_ADDR_TLOW: rd_next = ivl_reg[7:0];
            PMAS_ADDR_THIGH: rd_next = {5'h00, ivl_reg[10:8]};
            default: rd_next = 8'h00;
        endcase
    end

    // register file stage: gates, auto-sleep enable and interval
    // clock gates come up off so no block burns power before it is set up
    always_ff @(posedge mclk) begin
        if (rst) begin
            gate_reg <= PMAS_GATE_RESET;
            auto_reg <= 1'b0; // auto-sleep off until software arms it
            ivl_reg <= PMAS_IVL_RESET;
        end else begin
            gate_reg <= gate_next;
            auto_reg <= auto_next;
            ivl_reg <= ivl_next;
        end
    end

    // mode machine stage: the device wakes from reset in operation mode
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= PMAS_ST_OPER;
            left_reg <= PMAS_IVL_RESET; // matches the reset interval
        end else begin
            state_reg <= state_next;
            left_reg <= left_next;
        end
    end

    // output stage: every top-level output leaves straight from a flip-flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_reg <= 8'h00;
            ctl_reg <= '0;
        end else begin
            rd_reg <= rd_next;
            ctl_reg <= ctl_next;
        end
    end
    assign rd_data = rd_reg;
    assign ctl = ctl_reg;

    // a sleep write lands in the mode register, then stays on the output
    AST_SLEEP_WRITE: assert property (@(posedge mclk) disable iff (rst)
        wr_sleep |=> state_reg == PMAS_ST_SLEEP ##1 ctl.sleeping)
        else $error("sleep write did not enter sleep");
    // reserved mode codes change nothing unless the countdown runs out
    AST_RESERVED_MODE: assert property (@(posedge mclk) disable iff (rst)
        req.wr && req.addr == PMAS_ADDR_MODE && req.data[1] && !expire
        |=> state_reg == $past(state_reg))
        else $error("reserved mode code changed the mode");
    // only a write of operation mode leaves sleep
    AST_SLEEP_HOLD: assert property (@(posedge mclk) disable iff (rst)
        state_reg == PMAS_ST_SLEEP && !wr_oper |=> state_reg == PMAS_ST_SLEEP)
        else $error("left sleep without a write");
    // the mode read shows the mode in force, reserved bits zero
    AST_MODE_READ: assert property (@(posedge mclk) disable iff (rst)
        rd_addr == PMAS_ADDR_MODE |=> rd_data == {6'h00,
        (($past(state_reg) == PMAS_ST_OPER) ? PMAS_MODE_OPER : PMAS_MODE_SLEEP)})
        else $error("mode read wrong");
    // the pwm kill comes up together with sleep
    AST_PWM_OFF: assert property (@(posedge mclk) disable iff (rst)
        $rose(ctl.sleeping) |-> ctl.pwm_kill)
        else $error("pwm not killed on sleep");
    // every step from operation into sleep switches the pwm outputs off
    AST_PWM_KILL_ENTRY: assert property (@(posedge mclk) disable iff (rst)
        state_reg == PMAS_ST_OPER ##1 state_reg == PMAS_ST_SLEEP |-> ctl.pwm_kill)
        else $error("pwm not killed on entry to sleep");
    // the shared pwm timer clock follows its gate bit
    AST_PWM_GATE: assert property (@(posedge mclk) disable iff (rst)
        req.wr && req.addr == PMAS_ADDR_GATE
        |=> ctl.pwm_clk_en == $past(req.data[PMAS_BIT_PWM]))
        else $error("pwm gate wrong");
    // the key scan clock follows its gate bit
    AST_KEY_GATE: assert property (@(posedge mclk) disable iff (rst)
        req.wr && req.addr == PMAS_ADDR_GATE
        |=> ctl.key_clk_en == $past(req.data[PMAS_BIT_KEY]))
        else $error("key gate wrong");
    // the gate read returns the stored gate bits
    AST_GATE_READ: assert property (@(posedge mclk) disable iff (rst)
        rd_addr == PMAS_ADDR_GATE |=> rd_data == $past(gate_reg))
        else $error("gate read wrong");
    // the enable bit takes its bit of the write
    AST_AUTO_WRITE: assert property (@(posedge mclk) disable iff (rst)
        req.wr && req.addr == PMAS_ADDR_AUTO |=> auto_reg == $past(req.data[PMAS_BIT_AUTO]))
        else $error("auto enable write wrong");
    // with the enable clear only a write can end operation
    AST_NO_AUTO: assert property (@(posedge mclk) disable iff (rst)
        !auto_reg && state_reg == PMAS_ST_OPER && !wr_sleep |=> state_reg == PMAS_ST_OPER)
        else $error("auto sleep while disabled");
    // a finished countdown always reaches sleep
    AST_EXPIRE: assert property (@(posedge mclk) disable iff (rst)
        expire |=> state_reg == PMAS_ST_SLEEP)
        else $error("expiry missed");
    // each step with no event takes one off the count until it is down to one
    AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (rst)
        armed && step && !activity && left_reg != 11'h001
        |=> left_reg == $past(left_reg) - 11'h001)
        else $error("countdown missed a step");
    // a zero interval never lets the countdown end operation
    AST_ZERO_IVL: assert property (@(posedge mclk) disable iff (rst)
        ivl_reg == 11'h000 && state_reg == PMAS_ST_OPER && !wr_sleep
        |=> state_reg == PMAS_ST_OPER)
        else $error("zero interval expired");
    // the low interval byte lands on its own
    AST_IVL_LOW: assert property (@(posedge mclk) disable iff (rst)
        req.wr && req.addr == PMAS_ADDR_TLOW |=> ivl_reg[7:0] == $past(req.data))
        else $error("interval low byte write wrong");
    // the high interval byte keeps only its three defined bits
    AST_IVL_HIGH: assert property (@(posedge mclk) disable iff (rst)
        req.wr && req.addr == PMAS_ADDR_THIGH |=> ivl_reg[10:8] == $past(req.data[2:0]))
        else $error("interval high byte write wrong");
    // the five reserved high bits read back as zero
    AST_HIGH_READ: assert property (@(posedge mclk) disable iff (rst)
        rd_addr == PMAS_ADDR_THIGH |=> rd_data[7:3] == 5'h00)
        else $error("interval high reserved bits set");
    // an event restarts the count from the full interval
    AST_RELOAD: assert property (@(posedge mclk) disable iff (rst)
        activity |=> left_reg == $past(ivl_reg))
        else $error("counter not reloaded");
    // while not armed the count sits at the full interval
    AST_IDLE_RELOAD: assert property (@(posedge mclk) disable iff (rst)
        !armed |=> left_reg == $past(ivl_reg))
        else $error("counter not held at interval while idle");
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// tb_top: register-level bench for the power mode and auto-sleep block
// assumes pmas_top with its byte register port, one mclk at 10 MHz
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pmas_pkg::*;
    localparam int STEP = 4; // short step keeps idle waits brief
    logic mclk = 1'b0; // 100 ns period
    logic rst = 1'b1; // held for the first 12 cycles
    pmas_req_type req = '0; // write port
    logic [7:0] rd_addr = 8'h00; // read address, level
    logic activity = 1'b0; // processing event pulse
    logic [7:0] rd_data;
    pmas_ctl_type ctl;
    int failures = 0;
    int total_checks = 0;
    pmas_top #(.STEP_CYC(STEP)) dut (.mclk(mclk), .rst(rst), .req(req), .rd_addr(rd_addr),
        .activity(activity), .rd_data(rd_data), .ctl(ctl));
    // free-running clock
    initial begin
        forever #50 mclk = ~mclk;
    end
    // compare one value, four-state exact
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // step n edges, then settle 1 ns past the edge
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one-cycle write strobe
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 req = '{1'b1, a, d};
        tick(1);
        req.wr = 1'b0;
    endtask
    // rd_data lands one edge after the address; two edges leaves margin
    task rd_chk(input string name, input logic [7:0] a, input logic [7:0] e);
        rd_addr = a;
        tick(2);
        chk(name, e, rd_data);
    endtask
    // events every third cycle, faster than two 4-cycle steps can expire
    task busy(input int n);
        repeat (n) begin
            activity = 1'b1;
            tick(1);
            activity = 1'b0;
            tick(2);
        end
    endtask
    // bounded wait for sleep; what is left of two steps plus the step register fits in six
    // ticks, so a countdown one step too long runs out and fails the run
    task wait_sleep;
        int i;
        for (i = 0; i < 6; i++) begin
            if (ctl.sleeping === 1'b1) break;
            tick(1);
        end
        if (i == 6) begin
            chk("sleep_wait", 8'h01, {7'h00, ctl.sleeping});
            tally_and_finish();
        end
    endtask
    task tally_and_finish;
        if (failures == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        tick(12);
        rst = 1'b0;
        wr(8'h89, 8'hFF);
        rd_chk("mode", 8'h88, 8'h01);
        rd_chk("gate", 8'h8A, 8'h00);
        rd_chk("auto", 8'h8B, 8'h00);
        rd_chk("tlow", 8'h8C, 8'hFF);
        rd_chk("thigh", 8'h8D, 8'h00);
        rd_chk("unmapped", 8'h89, 8'h00);
        wr(8'h8A, 8'hFF);
        rd_chk("gate", 8'h8A, 8'h05);
        chk("pwm_clk", 8'h01, {7'h00, ctl.pwm_clk_en});
        chk("key_clk", 8'h01, {7'h00, ctl.key_clk_en});
        wr(8'h8A, 8'h01);
        tick(2);
        chk("pwm_clk", 8'h00, {7'h00, ctl.pwm_clk_en});
        chk("key_clk", 8'h01, {7'h00, ctl.key_clk_en});
        wr(8'h8D, 8'hFF);
        rd_chk("thigh", 8'h8D, 8'h07);
        wr(8'h8D, 8'h00);
        wr(8'h8C, 8'h02);
        rd_chk("tlow", 8'h8C, 8'h02);
        wr(8'h88, 8'h02);
        rd_chk("mode", 8'h88, 8'h01);
        // arm with interval 2, keep busy, then go idle
        wr(8'h8B, 8'hFF);
        rd_chk("auto", 8'h8B, 8'h01);
        busy(10);
        chk("busy_sleep", 8'h00, {7'h00, ctl.sleeping});
        tick(3);
        chk("early_sleep", 8'h00, {7'h00, ctl.sleeping});
        wait_sleep();
        chk("pwm_kill", 8'h01, {7'h00, ctl.pwm_kill});
        rd_chk("mode", 8'h88, 8'h00);
        // disabled auto-sleep must not expire
        wr(8'h8B, 8'h00);
        wr(8'h88, 8'h01);
        tick(40);
        chk("auto_off", 8'h00, {7'h00, ctl.sleeping});
        // zero interval with enable set must not expire
        wr(8'h8C, 8'h00);
        wr(8'h8B, 8'h01);
        tick(40);
        chk("ivl_zero", 8'h00, {7'h00, ctl.sleeping});
        // forced sleep whatever the auto settings
        wr(8'h88, 8'h00);
        tick(2);
        chk("forced", 8'h01, {7'h00, ctl.sleeping});
        chk("pwm_kill", 8'h01, {7'h00, ctl.pwm_kill});
        tally_and_finish();
    end
endmodule
`default_nettype wire
